// >>> hw/drsc_pkg.sv
// constants, field layouts and state codes of the drive setpoint and restart control block
// assumes one 20 MHz clock and a register port with 4-bit word address and 16-bit data
package drsc_pkg;
  localparam int DW = 16;
  localparam int AW = 4;
  localparam int FW = 12;
  // register word addresses
  localparam logic [3:0] A_CTRL = 4'h0;
  localparam logic [3:0] A_ATT = 4'h1;
  localparam logic [3:0] A_DLY = 4'h2;
  localparam logic [3:0] A_PRE1 = 4'h3;
  localparam logic [3:0] A_PRE2 = 4'h4;
  localparam logic [3:0] A_PRE3 = 4'h5;
  localparam logic [3:0] A_ACTR = 4'h6;
  localparam logic [3:0] A_ABW = 4'h7;
  localparam logic [3:0] A_RPMS = 4'h8;
  localparam logic [3:0] A_BASE = 4'h9;
  localparam logic [3:0] A_MAXF = 4'ha;
  localparam logic [3:0] A_MINF = 4'hb;
  localparam logic [3:0] A_LOCK = 4'hc;
  localparam logic [3:0] A_STAT = 4'hd;
  localparam logic [3:0] A_SETP = 4'he;
  localparam logic [3:0] A_FOUT = 4'hf;
  // control register fields
  localparam int C_SRC = 0;
  localparam int C_RPM = 2;
  localparam int C_AUTO = 3;
  localparam int C_REMOTE = 4;
  localparam logic [1:0] SRC_MULTI = 2'h3;
  // reset values and limits, frequencies in 0.1 Hz
  localparam logic [15:0] CTRL_RST = 16'h0000;
  localparam logic [3:0] ATT_RST = 4'h0;
  localparam logic [3:0] ATT_MAX = 4'ha;
  localparam logic [5:0] DLY_RST = 6'h01;
  localparam logic [5:0] DLY_MAX = 6'h32;
  localparam logic [11:0] PRE_RST = 12'h0c8;
  localparam logic [11:0] ABW_MAX = 12'h064;
  localparam logic [11:0] MAXF_RST = 12'h258;
  localparam logic [11:0] MINF_RST = 12'h005;
  localparam logic [15:0] RPMS_RST = 16'h06d6;
  localparam logic [15:0] LOCK_KEY = 16'h0101;
  // fault input bits; the low five are restart eligible
  localparam int F_OVERTEMP = 0;
  localparam int F_OVERCUR = 1;
  localparam int F_HIGH_BUS = 2;
  localparam int F_LOW_BUS = 3;
  localparam int F_OVERLOAD = 4;
  localparam logic [7:0] RESTART_MASK = 8'h1f;
  localparam logic [3:0] HIGH_BUS_FAULT_CODE = 4'h3;
  localparam logic [3:0] LOW_BUS_FAULT_CODE = 4'h4;
  // timing
  localparam int CLK_HZ = 20000000;
  localparam int TICK_MS = 1000;
  localparam int TICK_CYC = CLK_HZ / 1000 * TICK_MS;
  localparam int RUN_OK_MIN = 5;
  localparam logic [8:0] RUN_OK_S = 9'(RUN_OK_MIN * 60);
  // display prefix selection
  localparam logic [1:0] DSP_SPEED = 2'h0;
  localparam logic [1:0] RESTART_COUNTDOWN_PREFIX = 2'h1;
  localparam logic [1:0] DSP_FAULT = 2'h2;
  typedef enum logic [4:0] {
    RS_IDLE = 5'h01,
    RS_WAIT = 5'h02,
    RS_RUN = 5'h04,
    RS_SPENT = 5'h08,
    RS_HOLD = 5'h10
  } drsc_rs_e;
endpackage : drsc_pkg

// >>> hw/drsc_top.sv
// setpoint selection, avoidance band, terminal decode, lockout, autostart and auto-restart
// assumes pins on TERM_IN and keys are asynchronous; fault, ready and reference are on CLK
`timescale 1ns/1ps
module drsc_top #(
  parameter int TICK_CYCLES = drsc_pkg::TICK_CYC
) (
  input wire logic CLK,
  input wire logic RST,
  input wire logic [3:0] ADDR,
  input wire logic [15:0] WDATA,
  input wire logic WR,
  input wire logic RD,
  output logic [15:0] RDATA,
  input wire logic [3:0] TERM_IN,
  input wire logic KEY_UP,
  input wire logic KEY_DOWN,
  input wire logic KEY_STOP,
  input wire logic FUNC_LOSS,
  input wire logic [7:0] FAULT_IN,
  input wire logic CHECKSUM_ERR,
  input wire logic PWR_READY,
  input wire logic [11:0] REF_TB,
  output logic RUN_CMD,
  output logic DIR_REV,
  output logic START_PULSE,
  output logic FAULT_RESET,
  output logic [11:0] FREQ_REF,
  output logic [1:0] DISP_PREFIX,
  output logic [15:0] DISP_VALUE,
  output logic DISP_DP,
  output logic DISP_FLASH,
  output logic LOG_STROBE,
  output logic [3:0] LOG_CODE
);
  typedef struct packed {
    logic [7:0] s1;
    logic [7:0] s2;
    logic [7:0] pv;
    logic [15:0] ctrl;
    logic [3:0] att;
    logic [5:0] dly;
    logic [11:0] pre1;
    logic [11:0] pre2;
    logic [11:0] pre3;
    logic [11:0] actr;
    logic [11:0] abw;
    logic [11:0] maxf;
    logic [11:0] minf;
    logic [15:0] rpms;
    logic [15:0] base;
    logic [15:0] sp;
    logic lock;
    drsc_pkg::drsc_rs_e st;
    logic [3:0] rem;
    logic [5:0] cnt;
    logic [8:0] runs;
    logic [24:0] pres;
    logic tick;
    logic [7:0] fprev;
    logic [3:0] code;
    logic rdy_prev;
    logic run;
    logic dir;
    logic start_p;
    logic freset_p;
    logic [11:0] fref;
    logic [1:0] dpre;
    logic [15:0] dval;
    logic ddp;
    logic dflash;
    logic log_s;
    logic [3:0] log_c;
    logic [15:0] rdata;
  } drsc_st_s;

  drsc_st_s r_reg;
  drsc_st_s r_next;
  logic [7:0] pins;
  logic [3:0] tb;
  logic [3:0] tb_rise;
  logic up_e;
  logic dn_e;
  logic kstop;
  logic floss;
  logic multi;
  logic [7:0] fault_new;
  logic any_f;
  logic nonr;
  logic rst_new;
  logic [1:0] sel;
  logic [31:0] sp_hz;
  logic [11:0] sp_freq;
  logic [11:0] req;
  logic [11:0] half;
  logic [11:0] lo;
  logic [12:0] hi;
  logic in_band;
  logic [11:0] fout;
  logic [31:0] rpm_disp;
  logic [3:0] new_code;

  // pins pass two flops; edges are taken only from the second stage
  assign pins = {FUNC_LOSS, KEY_STOP, KEY_DOWN, KEY_UP, TERM_IN};
  assign tb = r_reg.s2[3:0];
  assign tb_rise = r_reg.s2[3:0] & ~r_reg.pv[3:0];
  assign up_e = r_reg.s2[4] & ~r_reg.pv[4];
  assign dn_e = r_reg.s2[5] & ~r_reg.pv[5];
  assign kstop = r_reg.s2[6];
  assign floss = r_reg.s2[7];
  assign multi = (r_reg.ctrl[drsc_pkg::C_SRC +: 2] == drsc_pkg::SRC_MULTI);

  // fault classification
  assign fault_new = FAULT_IN & ~r_reg.fprev;
  assign any_f = |FAULT_IN;
  assign nonr = |(FAULT_IN & ~drsc_pkg::RESTART_MASK);
  assign rst_new = |(fault_new & drsc_pkg::RESTART_MASK);

  // lowest set bit of the new faults names the logged fault
  always_comb
  begin
    new_code = 4'h0;
    for (int i = 7; i >= 0; i--)
    begin
      if (fault_new[i])
        new_code = 4'(i + 1);
    end
  end

  // rpm setpoint scaled to frequency; zero scaling guarded to avoid a divide by zero
  assign sp_hz = (r_reg.rpms == 16'h0000) ? 32'h0 :
    (32'(r_reg.sp) * 32'(r_reg.maxf)) / 32'(r_reg.rpms);
  assign sp_freq = r_reg.ctrl[drsc_pkg::C_RPM] ? sp_hz[11:0] : r_reg.sp[11:0];

  // reference source: in mode 3 a preset, or the terminal reference with both select pins open, else remote terminal or local setpoint
  assign sel = {tb[1], tb[2]};
  always_comb
  begin
    req = sp_freq;
    if (multi)
    begin
      unique case (sel)
        2'h0: req = REF_TB;
        2'h1: req = r_reg.pre1;
        2'h2: req = r_reg.pre2;
        2'h3: req = r_reg.pre3;
      endcase
    end
    else if (r_reg.ctrl[drsc_pkg::C_REMOTE])
      req = REF_TB;
  end

  // avoidance band: an in-band request is parked at the lower edge, so the
  // ramp may still cross the band but never settles in it
  assign half = r_reg.abw >> 1;
  assign lo = (r_reg.actr > half) ? r_reg.actr - half : 12'h000;
  assign hi = {1'b0, r_reg.actr} + {1'b0, half};
  assign in_band = (r_reg.abw != 12'h000) && (req > lo) && ({1'b0, req} <= hi);
  assign fout = in_band ? lo : req;

  // speed monitor in rpm, integer units
  assign rpm_disp = (r_reg.maxf == 12'h000) ? 32'h0 :
    (32'(fout) * 32'(r_reg.rpms)) / 32'(r_reg.maxf);

  // whole next state in one place
  always_comb
  begin
    r_next = r_reg;
    r_next.s1 = pins;
    r_next.s2 = r_reg.s1;
    r_next.pv = r_reg.s2;
    r_next.fprev = FAULT_IN;
    r_next.rdy_prev = PWR_READY;
    r_next.start_p = 1'b0;
    r_next.freset_p = 1'b0;
    r_next.log_s = 1'b0;
    r_next.tick = 1'b0;
    r_next.rdata = 16'h0000;
    // one-second prescaler
    if (r_reg.pres == 25'(TICK_CYCLES - 1))
    begin
      r_next.pres = 25'h0;
      r_next.tick = 1'b1;
    end
    else
      r_next.pres = r_reg.pres + 25'h1;
    // register writes, refused under lockout except the lockout word
    if (WR && (!r_reg.lock || ADDR == drsc_pkg::A_LOCK))
    begin
      unique case (ADDR)
        drsc_pkg::A_CTRL: r_next.ctrl = WDATA;
        drsc_pkg::A_ATT: r_next.att = (WDATA > 16'(drsc_pkg::ATT_MAX)) ?
          drsc_pkg::ATT_MAX : WDATA[3:0];
        drsc_pkg::A_DLY: r_next.dly = (WDATA == 16'h0) ? drsc_pkg::DLY_RST :
          (WDATA > 16'(drsc_pkg::DLY_MAX)) ? drsc_pkg::DLY_MAX : WDATA[5:0];
        drsc_pkg::A_PRE1: r_next.pre1 = WDATA[11:0];
        drsc_pkg::A_PRE2: r_next.pre2 = WDATA[11:0];
        drsc_pkg::A_PRE3: r_next.pre3 = WDATA[11:0];
        drsc_pkg::A_ACTR: r_next.actr = WDATA[11:0];
        drsc_pkg::A_ABW: r_next.abw = (WDATA > 16'(drsc_pkg::ABW_MAX)) ?
          drsc_pkg::ABW_MAX : WDATA[11:0];
        drsc_pkg::A_RPMS: r_next.rpms = WDATA;
        drsc_pkg::A_BASE: r_next.base = WDATA;
        drsc_pkg::A_MAXF: r_next.maxf = WDATA[11:0];
        drsc_pkg::A_MINF: r_next.minf = WDATA[11:0];
        drsc_pkg::A_LOCK:
          if (WDATA == drsc_pkg::LOCK_KEY)
            r_next.lock = ~r_reg.lock;
        drsc_pkg::A_SETP: r_next.sp = WDATA;
        default: r_next.rdata = 16'h0000; // status words are read only
      endcase
    end
    // reads answer in the next cycle only
    if (RD)
    begin
      unique case (ADDR)
        drsc_pkg::A_CTRL: r_next.rdata = r_reg.ctrl;
        drsc_pkg::A_ATT: r_next.rdata = {12'h000, r_reg.att};
        drsc_pkg::A_DLY: r_next.rdata = {10'h000, r_reg.dly};
        drsc_pkg::A_PRE1: r_next.rdata = {4'h0, r_reg.pre1};
        drsc_pkg::A_PRE2: r_next.rdata = {4'h0, r_reg.pre2};
        drsc_pkg::A_PRE3: r_next.rdata = {4'h0, r_reg.pre3};
        drsc_pkg::A_ACTR: r_next.rdata = {4'h0, r_reg.actr};
        drsc_pkg::A_ABW: r_next.rdata = {4'h0, r_reg.abw};
        drsc_pkg::A_RPMS: r_next.rdata = r_reg.rpms;
        drsc_pkg::A_BASE: r_next.rdata = r_reg.base;
        drsc_pkg::A_MAXF: r_next.rdata = {4'h0, r_reg.maxf};
        drsc_pkg::A_MINF: r_next.rdata = {4'h0, r_reg.minf};
        drsc_pkg::A_LOCK: r_next.rdata = {15'h0000, r_reg.lock};
        drsc_pkg::A_STAT: r_next.rdata = {r_reg.lock, r_reg.rem, r_reg.cnt, r_reg.st};
        drsc_pkg::A_SETP: r_next.rdata = r_reg.sp;
        drsc_pkg::A_FOUT: r_next.rdata = {r_reg.code, r_reg.fref};
      endcase
    end
    // local setpoint keys: one rpm or one 0.1 Hz step per press
    if (up_e && !dn_e)
    begin
      if (r_reg.ctrl[drsc_pkg::C_RPM] ? (r_reg.sp < r_reg.rpms) :
          (r_reg.sp < 16'(r_reg.maxf)))
        r_next.sp = r_reg.sp + 16'h1;
    end
    else if (dn_e && !up_e)
    begin
      if (r_reg.ctrl[drsc_pkg::C_RPM] ? (r_reg.sp != 16'h0) :
          (r_reg.sp > 16'(r_reg.minf)))
        r_next.sp = r_reg.sp - 16'h1;
    end
    // terminal decode
    r_next.dir = tb[3];
    if (multi)
    begin
      r_next.run = tb[0]; // open stops, closed runs
      if (tb_rise[0])
        r_next.freset_p = 1'b1;
    end
    else
    begin
      if (tb_rise[1])
        r_next.run = 1'b1;
      if (tb[0])
        r_next.run = 1'b0;
      if (tb_rise[2])
        r_next.freset_p = 1'b1;
    end
    if (kstop || any_f)
      r_next.run = 1'b0;
    // power-up autostart on the rising ready edge, gated by every permissive
    if (PWR_READY && !r_reg.rdy_prev && r_reg.ctrl[drsc_pkg::C_AUTO] &&
        !CHECKSUM_ERR && !floss && !kstop && !any_f)
    begin
      if (!r_reg.ctrl[drsc_pkg::C_REMOTE])
      begin
        r_next.start_p = 1'b1;
        r_next.run = 1'b1;
      end
      else if (multi ? tb[0] : tb[1])
        r_next.run = 1'b1;
    end
    // auto-restart sequencer
    unique case (r_reg.st)
      drsc_pkg::RS_IDLE:
      begin
        if (fault_new != 8'h00)
        begin
          r_next.log_s = 1'b1;
          r_next.log_c = new_code;
          r_next.code = new_code;
          if (rst_new && r_reg.att != 4'h0)
          begin
            if (nonr)
              r_next.st = drsc_pkg::RS_HOLD;
            else
            begin
              r_next.st = drsc_pkg::RS_WAIT;
              r_next.rem = r_reg.att;
              r_next.cnt = r_reg.dly;
            end
          end
        end
      end
      drsc_pkg::RS_WAIT:
      begin
        if (nonr)
          r_next.st = drsc_pkg::RS_HOLD;
        else if (r_reg.tick)
        begin
          if (r_reg.cnt <= 6'h01)
          begin
            r_next.cnt = 6'h00;
            r_next.st = drsc_pkg::RS_RUN;
            r_next.runs = 9'h000;
            r_next.freset_p = 1'b1;
            r_next.run = 1'b1;
          end
          else
            r_next.cnt = r_reg.cnt - 6'h01;
        end
      end
      drsc_pkg::RS_RUN:
      begin
        if (nonr)
          r_next.st = drsc_pkg::RS_HOLD;
        else if (rst_new) // repeat occurrences are not logged
        begin
          if (r_reg.rem <= 4'h1)
            r_next.st = drsc_pkg::RS_SPENT;
          else
          begin
            r_next.rem = r_reg.rem - 4'h1;
            r_next.cnt = r_reg.dly;
            r_next.st = drsc_pkg::RS_WAIT;
          end
        end
        else if (r_reg.tick)
        begin
          if (r_reg.runs == drsc_pkg::RUN_OK_S - 9'h001)
            r_next.st = drsc_pkg::RS_IDLE;
          else
            r_next.runs = r_reg.runs + 9'h001;
        end
      end
      drsc_pkg::RS_SPENT, drsc_pkg::RS_HOLD:
      begin
        if (!any_f)
          r_next.st = drsc_pkg::RS_IDLE;
      end
      default: r_next.st = drsc_pkg::RS_IDLE;
    endcase
    // display and output reference
    r_next.fref = fout;
    r_next.dflash = 1'b0;
    r_next.ddp = 1'b0;
    r_next.dpre = drsc_pkg::DSP_SPEED;
    if (r_next.st == drsc_pkg::RS_WAIT)
    begin
      r_next.dpre = drsc_pkg::RESTART_COUNTDOWN_PREFIX;
      r_next.dval = {10'h000, r_next.cnt};
      r_next.dflash = 1'b1;
    end
    else if (r_next.st == drsc_pkg::RS_SPENT)
    begin
      r_next.dpre = drsc_pkg::DSP_FAULT;
      r_next.dval = {12'h000, r_reg.code};
      r_next.dflash = 1'b1;
    end
    else if (!r_reg.ctrl[drsc_pkg::C_RPM] && r_reg.rpms == r_reg.base)
    begin
      r_next.dval = {4'h0, fout};
      r_next.ddp = 1'b1;
    end
    else
      r_next.dval = rpm_disp[15:0];
  end

  // the only clocked process
  always_ff @(posedge CLK)
  begin
    if (RST)
    begin
      r_reg <= '0;
      r_reg.ctrl <= drsc_pkg::CTRL_RST;
      r_reg.att <= drsc_pkg::ATT_RST;
      r_reg.dly <= drsc_pkg::DLY_RST;
      r_reg.pre1 <= drsc_pkg::PRE_RST;
      r_reg.pre2 <= drsc_pkg::PRE_RST;
      r_reg.pre3 <= drsc_pkg::PRE_RST;
      r_reg.maxf <= drsc_pkg::MAXF_RST;
      r_reg.minf <= drsc_pkg::MINF_RST;
      r_reg.rpms <= drsc_pkg::RPMS_RST;
      r_reg.base <= drsc_pkg::RPMS_RST;
      r_reg.st <= drsc_pkg::RS_IDLE;
    end
    else
      r_reg <= r_next;
  end

  assign RDATA = r_reg.rdata;
  assign RUN_CMD = r_reg.run;
  assign DIR_REV = r_reg.dir;
  assign START_PULSE = r_reg.start_p;
  assign FAULT_RESET = r_reg.freset_p;
  assign FREQ_REF = r_reg.fref;
  assign DISP_PREFIX = r_reg.dpre;
  assign DISP_VALUE = r_reg.dval;
  assign DISP_DP = r_reg.ddp;
  assign DISP_FLASH = r_reg.dflash;
  assign LOG_STROBE = r_reg.log_s;
  assign LOG_CODE = r_reg.log_c;

  // checks
  property p_att_max;
    @(posedge CLK) disable iff (RST) r_reg.att <= drsc_pkg::ATT_MAX;
  endproperty
  a_att_max: assert property (p_att_max) else $error("attempt count above ten");
  property p_att_zero;
    @(posedge CLK) disable iff (RST)
      (r_reg.st == drsc_pkg::RS_IDLE && r_reg.att == 4'h0) |=> r_reg.st != drsc_pkg::RS_WAIT;
  endproperty
  a_att_zero: assert property (p_att_zero) else $error("restart with zero attempts");
  property p_log_first;
    @(posedge CLK) disable iff (RST)
      (r_reg.st == drsc_pkg::RS_IDLE && fault_new != 8'h00) |=> LOG_STROBE;
  endproperty
  a_log_first: assert property (p_log_first) else $error("first fault not logged");
  property p_wait_load;
    @(posedge CLK) disable iff (RST)
      (r_reg.st == drsc_pkg::RS_IDLE && rst_new && !nonr && r_reg.att != 4'h0)
      |=> (r_reg.st == drsc_pkg::RS_WAIT && r_reg.cnt == $past(r_reg.dly));
  endproperty
  a_wait_load: assert property (p_wait_load) else $error("countdown not loaded");
  property p_tick;
    @(posedge CLK) disable iff (RST)
      (r_reg.st == drsc_pkg::RS_WAIT && !nonr && r_reg.tick && r_reg.cnt > 6'h01)
      |=> r_reg.cnt == $past(r_reg.cnt) - 6'h01;
  endproperty
  a_tick: assert property (p_tick) else $error("countdown step wrong");
  property p_issue;
    @(posedge CLK) disable iff (RST)
      (r_reg.st == drsc_pkg::RS_WAIT && !nonr && r_reg.tick && r_reg.cnt <= 6'h01)
      |=> FAULT_RESET && RUN_CMD ##1 !FAULT_RESET;
  endproperty
  a_issue: assert property (p_issue) else $error("restart not issued at zero");
  property p_spent;
    @(posedge CLK) disable iff (RST)
      (r_reg.st == drsc_pkg::RS_RUN && !nonr && rst_new && r_reg.rem <= 4'h1)
      |=> r_reg.st == drsc_pkg::RS_SPENT && DISP_FLASH && DISP_PREFIX == drsc_pkg::DSP_FAULT;
  endproperty
  a_spent: assert property (p_spent) else $error("exhausted retries not faulted");
  property p_nolog;
    @(posedge CLK) disable iff (RST) (r_reg.st != drsc_pkg::RS_IDLE) |=> !LOG_STROBE;
  endproperty
  a_nolog: assert property (p_nolog) else $error("repeat fault logged");
  property p_disp;
    @(posedge CLK) disable iff (RST)
      (r_reg.st == drsc_pkg::RS_WAIT) |-> DISP_FLASH &&
      DISP_PREFIX == drsc_pkg::RESTART_COUNTDOWN_PREFIX && DISP_VALUE == {10'h000, r_reg.cnt};
  endproperty
  a_disp: assert property (p_disp) else $error("countdown display wrong");
  property p_hold;
    @(posedge CLK) disable iff (RST)
      (nonr && (r_reg.st == drsc_pkg::RS_WAIT || r_reg.st == drsc_pkg::RS_RUN))
      |=> r_reg.st == drsc_pkg::RS_HOLD;
  endproperty
  a_hold: assert property (p_hold) else $error("restart not suppressed");
  property p_lock_wr;
    @(posedge CLK) disable iff (RST)
      (WR && r_reg.lock && ADDR != drsc_pkg::A_LOCK) |=> $stable(r_reg.ctrl) && $stable(r_reg.att);
  endproperty
  a_lock_wr: assert property (p_lock_wr) else $error("write passed lockout");
  property p_lock_tog;
    @(posedge CLK) disable iff (RST)
      (WR && ADDR == drsc_pkg::A_LOCK) |=> (r_reg.lock != $past(r_reg.lock)) ==
      ($past(WDATA) == drsc_pkg::LOCK_KEY);
  endproperty
  a_lock_tog: assert property (p_lock_tog) else $error("lockout toggle wrong");
  property p_band;
    @(posedge CLK) disable iff (RST)
      !WR |=> !(r_reg.abw != 12'h000 && FREQ_REF > lo && {1'b0, FREQ_REF} <= hi);
  endproperty
  a_band: assert property (p_band) else $error("output inside avoidance band");
  c_wait: cover property (@(posedge CLK) disable iff (RST) r_reg.st == drsc_pkg::RS_WAIT);
  c_spent: cover property (@(posedge CLK) disable iff (RST) r_reg.st == drsc_pkg::RS_SPENT);
  c_lock: cover property (@(posedge CLK) disable iff (RST) $rose(r_reg.lock));
  c_auto: cover property (@(posedge CLK) disable iff (RST) START_PULSE);
endmodule : drsc_top

// >>> test/drsc_panel.sv
// panel model: terminal strip contacts and fault sources facing the block
// assumes the bench names the wanted levels; lines change just after an edge
`timescale 1ns/1ps
module drsc_panel (
  input wire logic clk,
  input wire logic [3:0] term_want,
  input wire logic [7:0] flt_want,
  output logic [3:0] term_pins,
  output logic [7:0] flt_lines
);
  // contacts settle one clock late, like a real relay, never on the edge
  always_ff @(posedge clk)
  begin
    term_pins <= term_want;
    flt_lines <= flt_want;
  end
endmodule : drsc_panel

// >>> test/drsc_top_test.sv
// self-checking bench: registers, lockout, autostart, avoidance, presets, restart
// assumes the one-second tick is cut to 10 clocks; panel model drives pins
`timescale 1ns/1ps
module drsc_top_test;
  logic CLK = 1'b0;
  logic RST = 1'b1;
  logic [3:0] ADDR = 4'h0;
  logic [15:0] WDATA = 16'h0000;
  logic WR = 1'b0;
  logic RD = 1'b0;
  logic KEY_STOP = 1'b0;
  logic KEY_UP = 1'b0;
  logic PWR_READY = 1'b0;
  logic [11:0] REF_TB = 12'h000;
  logic [3:0] term_want = 4'h0;
  logic [7:0] flt_want = 8'h00;
  logic [3:0] TERM_IN, LOG_CODE;
  logic [7:0] FAULT_IN;
  logic [15:0] RDATA, DISP_VALUE;
  logic [11:0] FREQ_REF;
  logic [1:0] DISP_PREFIX;
  logic RUN_CMD, DIR_REV, START_PULSE, FAULT_RESET, DISP_DP, DISP_FLASH, LOG_STROBE;
  int failures = 0;
  int n_compared = 0;
  int n_log = 0;
  int n_sp = 0;
  int n_fr = 0;
  always #25 CLK = ~CLK;
  // pulse counters, so no one-cycle output can slip past a check
  // outputs are unknown before the first reset edge, so count only out of reset
  always @(posedge CLK)
  begin
    if (!RST)
    begin
      n_log <= n_log + LOG_STROBE;
      n_sp <= n_sp + START_PULSE;
      n_fr <= n_fr + FAULT_RESET;
    end
  end
  drsc_panel drsc_panel_inst (.clk(CLK), .term_want(term_want), .flt_want(flt_want),
    .term_pins(TERM_IN), .flt_lines(FAULT_IN));
  drsc_top #(.TICK_CYCLES(10)) drsc_top_inst (.CLK(CLK), .RST(RST), .ADDR(ADDR),
    .WDATA(WDATA), .WR(WR), .RD(RD), .RDATA(RDATA), .TERM_IN(TERM_IN), .KEY_UP(KEY_UP),
    .KEY_DOWN(1'b0), .KEY_STOP(KEY_STOP), .FUNC_LOSS(1'b0), .FAULT_IN(FAULT_IN),
    .CHECKSUM_ERR(1'b0), .PWR_READY(PWR_READY), .REF_TB(REF_TB), .RUN_CMD(RUN_CMD),
    .DIR_REV(DIR_REV), .START_PULSE(START_PULSE), .FAULT_RESET(FAULT_RESET),
    .FREQ_REF(FREQ_REF), .DISP_PREFIX(DISP_PREFIX), .DISP_VALUE(DISP_VALUE),
    .DISP_DP(DISP_DP), .DISP_FLASH(DISP_FLASH), .LOG_STROBE(LOG_STROBE),
    .LOG_CODE(LOG_CODE));
  task automatic test_done;
    if (failures == 0 && n_compared > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask : test_done
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_compared++;
    if (got !== exp)
    begin
      failures++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk
  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge CLK);
    ADDR <= a;
    WDATA <= d;
    WR <= 1'b1;
    @(posedge CLK);
    WR <= 1'b0;
  endtask : wr
  // read data only stand in the cycle after the strobe
  task automatic rdc(input logic [3:0] a, input logic [15:0] exp, input logic [15:0] m = 16'hffff);
    @(posedge CLK);
    ADDR <= a;
    RD <= 1'b1;
    @(posedge CLK);
    RD <= 1'b0;
    #1 chk(RDATA & m, exp);
  endtask : rdc
  task automatic wait_fr(input int target);
    for (int i = 0; i < 300 && n_fr < target; i++)
      @(posedge CLK) #1;
    if (n_fr < target)
    begin
      failures++;
      test_done();
    end
  endtask : wait_fr
  task automatic t_regs;
    logic [3:0] a [7] = '{4'h0, 4'h1, 4'h2, 4'h3, 4'ha, 4'hb, 4'h8};
    logic [15:0] v [7] = '{16'h0, 16'h0, 16'h1, 16'h00c8, 16'h0258, 16'h5, 16'h06d6};
    for (int i = 0; i < 7; i++)
      rdc(a[i], v[i]);
    wr(4'hc, 16'h0005);
    rdc(4'hc, 16'h0000, 16'h0001);
    wr(4'hc, 16'h0101);
    rdc(4'hc, 16'h0001, 16'h0001);
    wr(4'h1, 16'h0003);
    rdc(4'h1, 16'h0000);
    wr(4'hc, 16'h0101);
    wr(4'h1, 16'h000f);
    rdc(4'h1, 16'h000a);
    wr(4'h2, 16'h0000);
    rdc(4'h2, 16'h0001);
  endtask : t_regs
  // a held stop key must veto the power-up start, a clean one must not
  task automatic t_auto;
    wr(4'h0, 16'h0008);
    KEY_STOP <= 1'b1;
    repeat (5) @(posedge CLK);
    PWR_READY <= 1'b1;
    repeat (6) @(posedge CLK);
    #1 chk(n_sp, 0);
    PWR_READY <= 1'b0;
    KEY_STOP <= 1'b0;
    repeat (5) @(posedge CLK);
    PWR_READY <= 1'b1;
    repeat (4) @(posedge CLK);
    #1 chk(n_sp, 1);
    chk(RUN_CMD, 1);
  endtask : t_auto
  task automatic t_avoid;
    logic [11:0] rq [4] = '{12'h12c, 12'h12f, 12'h156, 12'h157};
    logic [11:0] ex [4] = '{12'h12c, 12'h12e, 12'h12e, 12'h157};
    wr(4'h0, 16'h0010);
    wr(4'h6, 16'h0142);
    wr(4'h7, 16'h0028);
    for (int i = 0; i < 4; i++)
    begin
      REF_TB <= rq[i];
      repeat (4) @(posedge CLK);
      #1 chk(FREQ_REF, ex[i]);
    end
    wr(4'h7, 16'h0000);
    REF_TB <= 12'h140;
    repeat (4) @(posedge CLK);
    #1 chk(FREQ_REF, 12'h140);
  endtask : t_avoid
  task automatic t_preset;
    logic [11:0] ex [4] = '{12'h04d, 12'h064, 12'h096, 12'h0fa};
    wr(4'h0, 16'h0003);
    wr(4'h3, 16'h0064);
    wr(4'h4, 16'h0096);
    wr(4'h5, 16'h00fa);
    REF_TB <= 12'h04d;
    for (int k = 0; k < 4; k++)
    begin
      term_want <= {k[0], k[0], k[1], 1'b0};
      repeat (6) @(posedge CLK);
      #1 chk(FREQ_REF, ex[k]);
      chk(DIR_REV, k[0]);
    end
  endtask : t_preset
  // one key press moves the rpm setpoint by one; hz shown only when scaling equals base
  task automatic t_rpm;
    wr(4'h0, 16'h0004);
    wr(4'he, 16'h06d3);
    KEY_UP <= 1'b1;
    repeat (5) @(posedge CLK);
    KEY_UP <= 1'b0;
    rdc(4'he, 16'h06d4);
    chk(FREQ_REF, 16'h0257);
    chk(DISP_VALUE, 16'h06d3);
    chk(DISP_DP, 1'b0);
    wr(4'h0, 16'h0000);
    wr(4'he, 16'h012c);
    repeat (2) @(posedge CLK);
    #1 chk(DISP_VALUE, 16'h012c);
    chk(DISP_DP, 1'b1);
    wr(4'h9, 16'h0708);
    repeat (2) @(posedge CLK);
    #1 chk(DISP_VALUE, 16'h036b);
    chk(DISP_DP, 1'b0);
  endtask : t_rpm
  // two retries allowed: second fault in the run window uses the last one
  task automatic t_restart;
    wr(4'h0, 16'h0000);
    wr(4'h1, 16'h0002);
    wr(4'h2, 16'h0002);
    flt_want <= 8'h02;
    repeat (4) @(posedge CLK);
    #1 chk(n_log, 1);
    chk(LOG_CODE, 16'h0002);
    chk(DISP_PREFIX, 2'h1);
    chk(DISP_FLASH, 1);
    flt_want <= 8'h00;
    wait_fr(1);
    chk(RUN_CMD, 1);
    // the last fault is held so the spent state and its display can be seen
    for (int k = 2; k < 4; k++)
    begin
      flt_want <= 8'h02;
      repeat (3) @(posedge CLK);
      if (k == 2)
        flt_want <= 8'h00;
      rdc(drsc_pkg::A_STAT, k == 2 ? 16'h0802 : 16'h0808, 16'h781f);
      if (k == 2)
        wait_fr(2);
    end
    chk(DISP_PREFIX, 2'h2);
    chk(DISP_VALUE, 16'h0002);
    chk(n_log, 1);
    flt_want <= 8'h00;
    repeat (4) @(posedge CLK);
    rdc(drsc_pkg::A_STAT, 16'h0001, 16'h001f);
  endtask : t_restart
  task automatic t_noauto;
    logic [7:0] f [2] = '{8'h20, 8'h22};
    logic [15:0] ex [2] = '{16'h0001, 16'h0010};
    for (int k = 0; k < 2; k++)
    begin
      flt_want <= f[k];
      repeat (5) @(posedge CLK);
      rdc(drsc_pkg::A_STAT, ex[k], 16'h001f);
      flt_want <= 8'h00;
      repeat (5) @(posedge CLK);
    end
  endtask : t_noauto
  // mode 0: start closes the run latch, stop opens it, reset terminal pulses
  task automatic t_term;
    int fr0;
    wr(4'h0, 16'h0000);
    term_want <= 4'h0;
    repeat (6) @(posedge CLK);
    fr0 = n_fr;
    term_want <= 4'h6;
    repeat (6) @(posedge CLK);
    #1 chk(RUN_CMD, 1);
    chk(n_fr, fr0 + 1);
    term_want <= 4'h7;
    repeat (6) @(posedge CLK);
    #1 chk(RUN_CMD, 0);
  endtask : t_term
  initial
  begin
    repeat (16) @(posedge CLK);
    RST <= 1'b0;
    t_regs();
    t_auto();
    t_avoid();
    t_preset();
    t_rpm();
    t_restart();
    t_noauto();
    t_term();
    test_done();
  end
endmodule : drsc_top_test
